// ==== dv/pcrs_core_model.sv ====
`timescale 1ns/1ns
module pcrs_core_model (
  input  wire pcrs_pkg::pcrs_op_t   op_i,
  input  wire pcrs_pkg::pcrs_addr_t tgt_i,
  output logic                      seq_adv_o,
  output logic                      jump_o,
  output logic                      call_o,
  output logic                      int_ack_o,
  output logic                      ret_o,
  output pcrs_pkg::pcrs_addr_t      target_o
);
  import pcrs_pkg::*;
  // one strobe per requested core operation, never two at once
  always_comb begin
    seq_adv_o = (op_i == PCRS_OP_ADV);
    jump_o    = (op_i == PCRS_OP_JUMP);
    call_o    = (op_i == PCRS_OP_CALL);
    int_ack_o = (op_i == PCRS_OP_INT);
    ret_o     = (op_i == PCRS_OP_RET);
    // target is junk unless a load is asked for
    target_o  = (jump_o | call_o | int_ack_o) ? tgt_i : ~tgt_i;
  end
endmodule

// ==== dv/pcrs_top_tb_top.sv ====
`timescale 1ns/1ns
`include "pcrs_map.svh"
module pcrs_top_tb_top;
  import pcrs_pkg::*;
  logic        clk;
  logic        rst;
  pcrs_op_t    op;
  pcrs_addr_t  tgt;
  logic        sa;
  logic        jp;
  logic        cl;
  logic        ia;
  logic        rt;
  pcrs_addr_t  tg;
  logic [3:0]  adr;
  logic [3:0]  be;
  logic        rd;
  logic        wr;
  logic [31:0] wd;
  logic [31:0] rdat;
  logic        wq;
  pcrs_addr_t  fp;
  pcrs_index_t ix;
  logic        fu;
  logic        ov;
  logic        un;
  int          err_total;
  int          samples_checked;
  pcrs_addr_t  exp_e [1:31];
  pcrs_addr_t  pe;

  pcrs_core_model pcrs_core_model_i (
    .op_i      (op),
    .tgt_i     (tgt),
    .seq_adv_o (sa),
    .jump_o    (jp),
    .call_o    (cl),
    .int_ack_o (ia),
    .ret_o     (rt),
    .target_o  (tg)
  );

  pcrs_top pcrs_top_i (
    .ref_clk_i            (clk),
    .rst_i                (rst),
    .seq_adv_i            (sa),
    .jump_i               (jp),
    .call_i               (cl),
    .int_ack_i            (ia),
    .ret_i                (rt),
    .target_i             (tg),
    .avs_address_i        (adr),
    .avs_read_i           (rd),
    .avs_write_i          (wr),
    .avs_writedata_i      (wd),
    .avs_byteenable_i     (be),
    .avs_readdata_o       (rdat),
    .avs_waitrequest_o    (wq),
    .fetch_pointer_o      (fp),
    .return_stack_index_o (ix),
    .stack_full_o         (fu),
    .stack_overflow_o     (ov),
    .stack_underflow_o    (un)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task final_report;
    if (err_total == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task chk_pin(input string nm, input logic [20:0] e, input logic [20:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task chk_reg(input logic [3:0] a, input logic [7:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== {24'h000000, e}) begin
      err_total++;
      $display("Error register %0d expected %h seen %h", a, e, g);
    end
  endtask

  // hold the request until waitrequest is sampled low
  task wait_ack;
    do begin
      @(posedge clk);
    end while (wq !== 1'b0);
  endtask

  task wr_reg(input logic [3:0] a, input logic [7:0] d, input logic [3:0] b);
    wr <= 1'b1;
    adr <= a;
    wd <= {24'h000000, d};
    be <= b;
    wait_ack();
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task rd_chk(input logic [3:0] a, input logic [7:0] e);
    logic [31:0] v;
    rd <= 1'b1;
    adr <= a;
    wait_ack();
    v = rdat;
    rd <= 1'b0;
    chk_reg(a, e, v);
    @(posedge clk);
  endtask

  task core(input pcrs_op_t o, input pcrs_addr_t t);
    op <= o;
    tgt <= t;
    @(posedge clk);
    op <= PCRS_OP_NONE;
    @(posedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    op = PCRS_OP_NONE;
    tgt = 21'h000000;
    rd = 1'b0;
    wr = 1'b0;
    adr = 4'h0;
    wd = 32'h00000000;
    be = 4'hF;
    err_total = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_pin("pointer", 21'h000000, fp);
    chk_pin("index", 21'h000000, ix);
    chk_pin("flags", 21'h000000, {fu, ov, un});
    for (int i = 0; i < 9; i++) rd_chk(4'(i), 8'h00);
    repeat (3) core(PCRS_OP_ADV, 21'h000000);
    chk_pin("pointer", 21'h000006, fp);
    wr_reg(`PCRS_IDX_LAT_HIGH, 8'h12, 4'h1);
    wr_reg(`PCRS_IDX_LAT_UPPER, 8'hFF, 4'h1);
    rd_chk(`PCRS_IDX_LAT_UPPER, 8'h1F);
    chk_pin("pointer", 21'h000006, fp);
    wr_reg(`PCRS_IDX_PC_LOW, 8'h35, 4'h1);
    chk_pin("pointer", 21'h1F1234, fp);
    // refused writes: lane off and unmapped place
    wr_reg(`PCRS_IDX_LAT_HIGH, 8'h77, 4'h0);
    wr_reg(4'h9, 8'h55, 4'h1);
    rd_chk(`PCRS_IDX_LAT_HIGH, 8'h12);
    wr_reg(`PCRS_IDX_LAT_HIGH, 8'h00, 4'h1);
    wr_reg(`PCRS_IDX_LAT_UPPER, 8'h00, 4'h1);
    rd_chk(`PCRS_IDX_PC_LOW, 8'h34);
    rd_chk(`PCRS_IDX_LAT_HIGH, 8'h12);
    rd_chk(`PCRS_IDX_LAT_UPPER, 8'h1F);
    wr_reg(`PCRS_IDX_LAT_HIGH, 8'h3C, 4'h1);
    core(PCRS_OP_JUMP, 21'h0ABCD);
    chk_pin("pointer", 21'h0ABCC, fp);
    core(PCRS_OP_CALL, 21'h000100);
    chk_pin("index", 21'h000001, ix);
    chk_pin("pointer", 21'h000100, fp);
    rd_chk(`PCRS_IDX_TOP_LOW, 8'hCC);
    rd_chk(`PCRS_IDX_TOP_HIGH, 8'hAB);
    rd_chk(`PCRS_IDX_TOP_UPPER, 8'h00);
    core(PCRS_OP_INT, 21'h000008);
    chk_pin("index", 21'h000002, ix);
    rd_chk(`PCRS_IDX_TOP_HIGH, 8'h01);
    core(PCRS_OP_RET, 21'h000000);
    chk_pin("pointer", 21'h000100, fp);
    chk_pin("index", 21'h000001, ix);
    rd_chk(`PCRS_IDX_LAT_HIGH, 8'h3C);
    rd_chk(`PCRS_IDX_LAT_UPPER, 8'h1F);
    // core stays idle while software touches the stack
    wr_reg(`PCRS_IDX_TOP_LOW, 8'h42, 4'h1);
    chk_pin("index", 21'h000001, ix);
    core(PCRS_OP_RET, 21'h000000);
    chk_pin("pointer", 21'h0AB42, fp);
    core(PCRS_OP_RET, 21'h000000);
    chk_pin("index", 21'h000000, ix);
    chk_pin("unf", 21'h000001, un);
    core(PCRS_OP_ADV, 21'h000000);
    rd_chk(`PCRS_IDX_STK_INDEX, 8'h40);
    wr_reg(`PCRS_IDX_STK_INDEX, 8'h00, 4'h1);
    chk_pin("flags", 21'h000000, {fu, ov, un});
    pe = 21'h000002;
    for (int i = 1; i < 32; i++) begin
      exp_e[i] = pe;
      core(PCRS_OP_CALL, 21'(i * 4));
      pe = 21'(i * 4);
    end
    chk_pin("index", 21'h00001F, ix);
    chk_pin("full", 21'h000001, fu);
    chk_pin("ovf", 21'h000000, ov);
    core(PCRS_OP_CALL, 21'h1FFFFE);
    chk_pin("ovf", 21'h000001, ov);
    chk_pin("index", 21'h00001F, ix);
    rd_chk(`PCRS_IDX_TOP_LOW, exp_e[31][7:0]);
    for (int i = 31; i > 0; i--) begin
      core(PCRS_OP_RET, 21'h000000);
      chk_pin("pointer", exp_e[i], fp);
    end
    chk_pin("full", 21'h000001, fu);
    wr_reg(`PCRS_IDX_STK_INDEX, 8'h00, 4'h1);
    wr_reg(`PCRS_IDX_STK_CTRL, 8'h01, 4'h1);
    chk_pin("index", 21'h000001, ix);
    rd_chk(`PCRS_IDX_TOP_LOW, 8'h02);
    wr_reg(`PCRS_IDX_STK_INDEX, 8'h03, 4'h1);
    rd_chk(`PCRS_IDX_STK_INDEX, 8'h03);
    wr_reg(`PCRS_IDX_STK_CTRL, 8'h02, 4'h1);
    chk_pin("index", 21'h000002, ix);
    chk_pin("pointer", 21'h000002, fp);
    rd_chk(`PCRS_IDX_STK_CTRL, 8'h00);
    wr_reg(`PCRS_IDX_STK_CTRL, 8'h03, 4'h1);
    chk_pin("index", 21'h000003, ix);
    wr_reg(`PCRS_IDX_STK_INDEX, 8'h00, 4'h1);
    wr_reg(`PCRS_IDX_TOP_LOW, 8'h99, 4'h1);
    rd_chk(`PCRS_IDX_TOP_LOW, 8'h00);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_pin("index", 21'h000000, ix);
    chk_pin("pointer", 21'h000000, fp);
    final_report();
  end
endmodule

// ==== hw/pcrs_avs_slave.sv ====
`timescale 1ns/1ns
module pcrs_avs_slave (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic read_i,
  input  wire logic write_i,
  output logic      waitrequest_o,
  output logic      rd_prep_o,
  output logic      rd_stb_o,
  output logic      wr_stb_o
);
  import pcrs_pkg::*;

  pcrs_slv_state_t st_r;
  pcrs_slv_state_t st_nxt;

  // one wait cycle, then a single ack cycle
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = (read_i || write_i) && !st_r.ack;
  end

  assign waitrequest_o = !st_r.ack;
  assign rd_prep_o     = read_i && !st_r.ack;
  assign rd_stb_o      = read_i && st_r.ack;
  assign wr_stb_o      = write_i && st_r.ack;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ==== hw/pcrs_map.svh ====
`ifndef PCRS_MAP_SVH
`define PCRS_MAP_SVH

// register word indices, byte address is four times the index
`define PCRS_IDX_PC_LOW     4'h0
`define PCRS_IDX_LAT_HIGH   4'h1
`define PCRS_IDX_LAT_UPPER  4'h2
`define PCRS_IDX_TOP_LOW    4'h3
`define PCRS_IDX_TOP_HIGH   4'h4
`define PCRS_IDX_TOP_UPPER  4'h5
`define PCRS_IDX_STK_INDEX  4'h6
`define PCRS_IDX_STK_CTRL   4'h7

// stack index register fields
`define PCRS_STK_IDX_MSB    4
`define PCRS_STK_FULL_BIT   5
`define PCRS_STK_UNF_BIT    6
`define PCRS_STK_OVF_BIT    7

// stack control register fields
`define PCRS_CTRL_PUSH_BIT  0
`define PCRS_CTRL_POP_BIT   1

// sizes and steps
`define PCRS_STK_DEPTH      5'h1F
`define PCRS_STK_EMPTY      5'h00
`define PCRS_PC_STEP        21'h000002

// reset values
`define PCRS_RST_PC         21'h000000
`define PCRS_RST_LAT_HIGH   8'h00
`define PCRS_RST_LAT_UPPER  5'h00
`define PCRS_RST_INDEX      5'h00

`endif

// ==== hw/pcrs_pkg.sv ====
package pcrs_pkg;

  typedef logic [20:0] pcrs_addr_t;
  typedef logic [4:0]  pcrs_index_t;

  typedef enum logic [2:0] {
    PCRS_OP_NONE,
    PCRS_OP_ADV,
    PCRS_OP_JUMP,
    PCRS_OP_CALL,
    PCRS_OP_INT,
    PCRS_OP_RET
  } pcrs_op_t;

  typedef struct packed {
    logic [31:1][20:0] ent;
  } pcrs_mem_state_t;

  typedef struct packed {
    logic ack;
  } pcrs_slv_state_t;

  typedef struct packed {
    pcrs_addr_t  pc;
    logic [7:0]  lat_high;
    logic [4:0]  lat_upper;
    pcrs_index_t idx;
    logic        full;
    logic        ovf;
    logic        unf;
    logic [31:0] rdata;
  } pcrs_top_state_t;

endpackage

// ==== hw/pcrs_stack_mem.sv ====
`timescale 1ns/1ns
`include "pcrs_map.svh"
module pcrs_stack_mem (
  input  wire logic               ref_clk_i,
  input  wire logic               rst_i,
  input  wire logic               wr_en_i,
  input  wire pcrs_pkg::pcrs_index_t wr_idx_i,
  input  wire pcrs_pkg::pcrs_addr_t  wr_data_i,
  input  wire pcrs_pkg::pcrs_index_t rd_idx_i,
  output pcrs_pkg::pcrs_addr_t       rd_data_o
);
  import pcrs_pkg::*;

  pcrs_mem_state_t st_r;
  pcrs_mem_state_t st_nxt;

  // slot zero has no storage and reads as zero
  always_comb begin
    st_nxt = st_r;
    if (wr_en_i && (wr_idx_i != `PCRS_STK_EMPTY)) begin
      st_nxt.ent[wr_idx_i] = wr_data_i;
    end
  end

  assign rd_data_o = (rd_idx_i == `PCRS_STK_EMPTY) ? `PCRS_RST_PC : st_r.ent[rd_idx_i];

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ==== hw/pcrs_top.sv ====
//
// Summary of operation
// - fetch pointer is 21 bits in three bytes
// - low byte accessible; high byte via latch only
// - upper bits updated only through upper latch
// - low byte write loads both latches into pointer
// - low byte read copies upper bytes to latches
// - pointer bit zero always reads zero
// - sequential advance adds two
// - jumps and calls load pointer directly
// - up to 31 nested calls and interrupts
// - call and interrupt push the pointer
// - returns pop top entry into pointer
// - call and return leave latches alone
// - stack is 31 by 21 bits, 5-bit index
// - software reads, writes, pushes, pops the stack
// - push increments index, then writes entry
// - pop reads entry, then decrements index
// - reset clears index; slot zero unbacked
// - full, overflow and underflow status bits
// - only top entry visible, as three bytes
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
`include "pcrs_map.svh"
module pcrs_top (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  seq_adv_i,
  input  wire logic                  jump_i,
  input  wire logic                  call_i,
  input  wire logic                  int_ack_i,
  input  wire logic                  ret_i,
  input  wire pcrs_pkg::pcrs_addr_t  target_i,
  input  wire logic [3:0]            avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  input  wire logic [3:0]            avs_byteenable_i,
  output logic [31:0]                avs_readdata_o,
  output logic                       avs_waitrequest_o,
  output pcrs_pkg::pcrs_addr_t       fetch_pointer_o,
  output pcrs_pkg::pcrs_index_t      return_stack_index_o,
  output logic                       stack_full_o,
  output logic                       stack_overflow_o,
  output logic                       stack_underflow_o
);
  import pcrs_pkg::*;

  pcrs_top_state_t st_r;
  pcrs_top_state_t st_nxt;

  logic        rd_prep;
  logic        rd_stb;
  logic        wr_stb;
  logic        wr_lane0;
  pcrs_op_t    op;
  pcrs_addr_t  top_val;
  logic        mem_we;
  pcrs_index_t mem_widx;
  pcrs_addr_t  mem_wdata;
  logic        core_stk;
  logic        sw_push;
  logic        sw_pop;
  logic        pcl_wr;
  logic        tos_wr;

  function automatic pcrs_addr_t align(input pcrs_addr_t a);
    align = {a[20:1], 1'b0};
  endfunction

  function automatic pcrs_addr_t put_byte(input pcrs_addr_t a, input logic [1:0] sel, input logic [7:0] b);
    pcrs_addr_t r;
    r = a;
    case (sel)
      2'h0: r[7:0] = b;
      2'h1: r[15:8] = b;
      default: r[20:16] = b[4:0];
    endcase
    put_byte = r;
  endfunction

  function automatic logic is_wr(input logic stb, input logic lane, input logic [3:0] adr, input logic [3:0] idx);
    is_wr = stb && lane && (adr == idx);
  endfunction

  pcrs_avs_slave u_slave (
    .ref_clk_i     (ref_clk_i),
    .rst_i         (rst_i),
    .read_i        (avs_read_i),
    .write_i       (avs_write_i),
    .waitrequest_o (avs_waitrequest_o),
    .rd_prep_o     (rd_prep),
    .rd_stb_o      (rd_stb),
    .wr_stb_o      (wr_stb)
  );

  pcrs_stack_mem u_mem (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .wr_en_i   (mem_we),
    .wr_idx_i  (mem_widx),
    .wr_data_i (mem_wdata),
    .rd_idx_i  (st_r.idx),
    .rd_data_o (top_val)
  );

  assign wr_lane0 = avs_byteenable_i[0];

  // core request priority
  always_comb begin
    if (int_ack_i) begin
      op = PCRS_OP_INT;
    end else if (call_i) begin
      op = PCRS_OP_CALL;
    end else if (ret_i) begin
      op = PCRS_OP_RET;
    end else if (jump_i) begin
      op = PCRS_OP_JUMP;
    end else if (seq_adv_i) begin
      op = PCRS_OP_ADV;
    end else begin
      op = PCRS_OP_NONE;
    end
  end

  assign core_stk = (op == PCRS_OP_INT) || (op == PCRS_OP_CALL) || (op == PCRS_OP_RET);
  assign sw_push  = is_wr(wr_stb, wr_lane0, avs_address_i, `PCRS_IDX_STK_CTRL)
                    && avs_writedata_i[`PCRS_CTRL_PUSH_BIT] && !core_stk;
  assign sw_pop   = is_wr(wr_stb, wr_lane0, avs_address_i, `PCRS_IDX_STK_CTRL)
                    && avs_writedata_i[`PCRS_CTRL_POP_BIT] && !avs_writedata_i[`PCRS_CTRL_PUSH_BIT] && !core_stk;
  assign pcl_wr   = is_wr(wr_stb, wr_lane0, avs_address_i, `PCRS_IDX_PC_LOW);
  assign tos_wr   = wr_stb && wr_lane0 && !core_stk && (st_r.idx != `PCRS_STK_EMPTY)
                    && ((avs_address_i == `PCRS_IDX_TOP_LOW) || (avs_address_i == `PCRS_IDX_TOP_HIGH)
                    || (avs_address_i == `PCRS_IDX_TOP_UPPER));

  always_comb begin
    st_nxt    = st_r;
    mem_we    = 1'b0;
    mem_widx  = st_r.idx;
    mem_wdata = top_val;

    // software side writes of latches, index and flags
    if (is_wr(wr_stb, wr_lane0, avs_address_i, `PCRS_IDX_LAT_HIGH)) begin
      st_nxt.lat_high = avs_writedata_i[7:0];
    end
    if (is_wr(wr_stb, wr_lane0, avs_address_i, `PCRS_IDX_LAT_UPPER)) begin
      st_nxt.lat_upper = avs_writedata_i[4:0];
    end
    if (is_wr(wr_stb, wr_lane0, avs_address_i, `PCRS_IDX_STK_INDEX)) begin
      st_nxt.full = st_r.full && avs_writedata_i[`PCRS_STK_FULL_BIT];
      st_nxt.ovf  = st_r.ovf && avs_writedata_i[`PCRS_STK_OVF_BIT];
      st_nxt.unf  = st_r.unf && avs_writedata_i[`PCRS_STK_UNF_BIT];
      if (!core_stk) begin
        st_nxt.idx = avs_writedata_i[`PCRS_STK_IDX_MSB:0];
      end
    end

    // low byte read snapshots upper bytes into latches
    if (rd_prep && (avs_address_i == `PCRS_IDX_PC_LOW)) begin
      st_nxt.lat_high  = st_r.pc[15:8];
      st_nxt.lat_upper = st_r.pc[20:16];
    end

    // pointer sequencing
    case (op)
      PCRS_OP_INT, PCRS_OP_CALL: begin
        st_nxt.pc = align(target_i);
      end
      PCRS_OP_RET: begin
        st_nxt.pc = align(top_val);
      end
      PCRS_OP_JUMP: begin
        st_nxt.pc = align(target_i);
      end
      PCRS_OP_ADV: begin
        st_nxt.pc = pcl_wr ? {st_r.lat_upper, st_r.lat_high, avs_writedata_i[7:1], 1'b0}
                           : align(st_r.pc + `PCRS_PC_STEP);
      end
      default: begin
        if (pcl_wr) begin
          st_nxt.pc = {st_r.lat_upper, st_r.lat_high, avs_writedata_i[7:1], 1'b0};
        end
      end
    endcase

    // push: index first, then entry gets the pointer
    if ((op == PCRS_OP_INT) || (op == PCRS_OP_CALL) || sw_push) begin
      if (st_r.idx == `PCRS_STK_DEPTH) begin
        st_nxt.ovf = 1'b1;
        st_nxt.idx = st_r.idx;
      end else begin
        st_nxt.idx = st_r.idx + 5'h01;
        mem_we     = 1'b1;
        mem_widx   = st_r.idx + 5'h01;
        mem_wdata  = st_r.pc;
        if (st_r.idx == (`PCRS_STK_DEPTH - 5'h01)) begin
          st_nxt.full = 1'b1;
        end
      end
    end

    // pop: entry already read out, then index drops
    if ((op == PCRS_OP_RET) || sw_pop) begin
      if (st_r.idx == `PCRS_STK_EMPTY) begin
        st_nxt.unf = 1'b1;
        st_nxt.idx = st_r.idx;
      end else begin
        st_nxt.idx = st_r.idx - 5'h01;
      end
    end

    // top entry byte writes keep the index
    if (tos_wr) begin
      mem_we    = 1'b1;
      mem_widx  = st_r.idx;
      case (avs_address_i)
        `PCRS_IDX_TOP_LOW:  mem_wdata = put_byte(top_val, 2'h0, avs_writedata_i[7:0]);
        `PCRS_IDX_TOP_HIGH: mem_wdata = put_byte(top_val, 2'h1, avs_writedata_i[7:0]);
        default:            mem_wdata = put_byte(top_val, 2'h2, avs_writedata_i[7:0]);
      endcase
    end

    // read data prepared during the wait cycle
    if (rd_prep) begin
      case (avs_address_i)
        `PCRS_IDX_PC_LOW:    st_nxt.rdata = {24'h000000, st_r.pc[7:1], 1'b0};
        `PCRS_IDX_LAT_HIGH:  st_nxt.rdata = {24'h000000, st_r.lat_high};
        `PCRS_IDX_LAT_UPPER: st_nxt.rdata = {27'h0000000, st_r.lat_upper};
        `PCRS_IDX_TOP_LOW:   st_nxt.rdata = {24'h000000, top_val[7:0]};
        `PCRS_IDX_TOP_HIGH:  st_nxt.rdata = {24'h000000, top_val[15:8]};
        `PCRS_IDX_TOP_UPPER: st_nxt.rdata = {27'h0000000, top_val[20:16]};
        `PCRS_IDX_STK_INDEX: st_nxt.rdata = {24'h000000, st_r.ovf, st_r.unf, st_r.full, st_r.idx};
        default:             st_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r.pc        <= `PCRS_RST_PC;
      st_r.lat_high  <= `PCRS_RST_LAT_HIGH;
      st_r.lat_upper <= `PCRS_RST_LAT_UPPER;
      st_r.idx       <= `PCRS_RST_INDEX;
      st_r.full      <= 1'b0;
      st_r.ovf       <= 1'b0;
      st_r.unf       <= 1'b0;
      st_r.rdata     <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata_o       = st_r.rdata;
  assign fetch_pointer_o      = st_r.pc;
  assign return_stack_index_o = st_r.idx;
  assign stack_full_o         = st_r.full;
  assign stack_overflow_o     = st_r.ovf;
  assign stack_underflow_o    = st_r.unf;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  AST_PC_ALIGNED: assert property (fetch_pointer_o[0] == 1'b0)
    else $error("fetch pointer misaligned");

  AST_ADV_STEP: assert property ((op == PCRS_OP_ADV) && !pcl_wr |=>
    fetch_pointer_o == pcrs_addr_t'($past(fetch_pointer_o) + 21'h000002))
    else $error("sequential step is not two");

  AST_JUMP_DIRECT: assert property ((op == PCRS_OP_JUMP) |=>
    fetch_pointer_o == {$past(target_i[20:1]), 1'b0})
    else $error("jump did not load target");

  AST_PCL_LOAD: assert property ((op == PCRS_OP_NONE) && pcl_wr |=>
    fetch_pointer_o == {$past(st_r.lat_upper), $past(st_r.lat_high), $past(avs_writedata_i[7:1]), 1'b0})
    else $error("low byte write did not merge latches");

  AST_PCL_SNAP: assert property (rd_prep && (avs_address_i == `PCRS_IDX_PC_LOW) |=>
    (st_r.lat_high == $past(fetch_pointer_o[15:8])) && (st_r.lat_upper == $past(fetch_pointer_o[20:16])))
    else $error("low byte read did not snapshot latches");

  AST_LATCH_KEEP: assert property (core_stk && !wr_stb && !rd_prep |=>
    $stable(st_r.lat_high) && $stable(st_r.lat_upper))
    else $error("call or return touched latches");

  AST_PUSH_IDX: assert property (((op == PCRS_OP_CALL) || (op == PCRS_OP_INT)) && (st_r.idx != 5'h1F) |=>
    (return_stack_index_o == pcrs_index_t'($past(st_r.idx) + 5'h01)) && (top_val == $past(st_r.pc)))
    else $error("push did not advance index with pointer");

  AST_POP: assert property ((op == PCRS_OP_RET) && (st_r.idx != 5'h00) |=>
    (return_stack_index_o == pcrs_index_t'($past(st_r.idx) - 5'h01)) && (fetch_pointer_o == align($past(top_val))))
    else $error("pop did not restore pointer and index");

  AST_OVERFLOW: assert property (((op == PCRS_OP_CALL) || (op == PCRS_OP_INT)) && (st_r.idx == 5'h1F) |=>
    stack_overflow_o && (return_stack_index_o == 5'h1F))
    else $error("overflow mishandled");

  AST_UNDERFLOW: assert property ((op == PCRS_OP_RET) && (st_r.idx == 5'h00) |=>
    stack_underflow_o && (return_stack_index_o == 5'h00))
    else $error("underflow mishandled");

  AST_FULL_SET: assert property (((op == PCRS_OP_CALL) || (op == PCRS_OP_INT)) && (st_r.idx == 5'h1E) |=>
    stack_full_o ##1 (stack_full_o || $past(wr_stb)))
    else $error("full flag not set at depth");

  AST_TOS_KEEP_IDX: assert property (tos_wr |=> $stable(return_stack_index_o))
    else $error("top entry write moved index");

  AST_BUS_ANSWER: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
    !avs_waitrequest_o)
    else $error("bus request not answered in one wait cycle");

  AST_CALL_LOAD: assert property ((op == PCRS_OP_CALL) |=>
    fetch_pointer_o == {$past(target_i[20:1]), 1'b0})
    else $error("call did not load target");

  AST_SW_PUSH: assert property (sw_push && (st_r.idx != 5'h1F) |=>
    (return_stack_index_o == pcrs_index_t'($past(st_r.idx) + 5'h01)) && (top_val == $past(st_r.pc)))
    else $error("software push mishandled");

  AST_SW_POP: assert property (sw_pop && (op == PCRS_OP_NONE) && (st_r.idx != 5'h00) |=>
    (return_stack_index_o == pcrs_index_t'($past(st_r.idx) - 5'h01)) && $stable(fetch_pointer_o))
    else $error("software pop mishandled");

  AST_RD_LOW: assert property (rd_prep && (avs_address_i == `PCRS_IDX_PC_LOW) |=>
    avs_readdata_o == {24'h000000, $past(fetch_pointer_o[7:0])})
    else $error("low byte read data wrong");

  AST_TOP_RD: assert property (rd_prep && (avs_address_i == `PCRS_IDX_TOP_LOW) |=>
    avs_readdata_o == {24'h000000, $past(top_val[7:0])})
    else $error("top entry read data wrong");

  AST_OVF_STICKY: assert property (stack_overflow_o && !wr_stb |=>
    stack_overflow_o)
    else $error("overflow flag dropped without a clear");

  AST_UNF_STICKY: assert property (stack_underflow_o && !wr_stb |=>
    stack_underflow_o)
    else $error("underflow flag dropped without a clear");

  AST_FULL_STICKY: assert property (stack_full_o && !wr_stb |=>
    stack_full_o)
    else $error("full flag dropped without a clear");

endmodule
